//--- idwba_consts.svh
`ifndef IDWBA_CONSTS_SVH
`define IDWBA_CONSTS_SVH
// -------------------------------------------------------------
// bank decode and timing
// -------------------------------------------------------------
`define IDWBA_BANK0_A2      1'b0
`define IDWBA_BANK1_A2      1'b1
`define IDWBA_BANK0_DSEL    1'b0
`define IDWBA_BANK1_DSEL    1'b1
`define IDWBA_CLK_PERIOD_NS 40
`define IDWBA_BUSY_TAIL_CLKS 1
// -------------------------------------------------------------
// reset values
// -------------------------------------------------------------
`define IDWBA_WE_RST        1'b0
`define IDWBA_BUSY_HOLD_RST 1'b0
`define IDWBA_CAS_REL_RST   1'b0
`define IDWBA_BURST_BIT_RST 1'b0
`endif

//--- idwba_pkg.sv
`default_nettype none
package idwba_pkg;
    typedef enum logic {sel_idle, sel_hold} idwba_sel_state_type;
    typedef enum logic {ba_track, ba_burst} idwba_ba_state_type;

    // burst-address inputs shared by both banks
    typedef struct packed {
        logic addr3;
        logic addr_latch_en;
        logic burst_start;
        logic burst_end;
        logic burst_ready_n;
        logic data_select;
        logic read_page_miss;
        logic row_addr13;
    } idwba_burst_in_type;

    typedef struct packed {
        idwba_ba_state_type state;
        logic               burst_bit;
    } idwba_ba_reg_type;

    typedef struct packed {
        idwba_sel_state_type sel0;
        idwba_sel_state_type sel1;
        logic                wen0;
        logic                wen1;
        logic                busy_hold;
        logic                cas_release;
    } idwba_wr_reg_type;
endpackage
`default_nettype wire

//--- idwba_low_addr.sv
`include "idwba_consts.svh"
`default_nettype none
module idwba_low_addr
    import idwba_pkg::*;
#(
    parameter logic BANK_DSEL = `IDWBA_BANK0_DSEL
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               resetn,
    // controls
    input  wire idwba_burst_in_type bi,
    input  wire logic               own_write_en,
    input  wire logic               any_write_en,
    input  wire logic               mux_addr_bit,
    // dram pin
    output logic                    low_addr_bit
);
    idwba_ba_reg_type st_reg;
    idwba_ba_reg_type st_next;

    always_comb begin
        st_next = st_reg;
        case (st_reg.state)
            ba_track: begin
                if (bi.addr_latch_en) begin
                    st_next.burst_bit = bi.addr3;
                end
                if (bi.burst_start) begin
                    st_next.state = ba_burst;
                end
            end
            ba_burst: begin
                // one toggle per ready clock keeps later words single-cycle
                if (!bi.burst_ready_n && bi.data_select == BANK_DSEL) begin
                    st_next.burst_bit = ~st_reg.burst_bit;
                end
                if (bi.burst_end) begin
                    st_next.state = ba_track;
                end
            end
            default: st_next.state = ba_track;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '{state: ba_track, burst_bit: `IDWBA_BURST_BIT_RST};
        end else begin
            st_reg <= st_next;
        end
    end

    // combinational so a write address reaches the pin in its own clock
    always_comb begin
        if (own_write_en) begin
            low_addr_bit = mux_addr_bit;
        end else if (bi.read_page_miss && !any_write_en) begin
            low_addr_bit = bi.row_addr13;
        end else begin
            low_addr_bit = st_reg.burst_bit;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_burst_toggle;
        st_reg.state == ba_burst && !bi.burst_ready_n && bi.data_select == BANK_DSEL
            |=> st_reg.burst_bit != $past(st_reg.burst_bit);
    endproperty
    a_burst_toggle: assert property (p_burst_toggle) else $error("burst bit did not toggle");
    property p_burst_still;
        st_reg.state == ba_burst && (bi.burst_ready_n || bi.data_select != BANK_DSEL)
            |=> st_reg.burst_bit == $past(st_reg.burst_bit);
    endproperty
    a_burst_still: assert property (p_burst_still) else $error("burst bit moved without ready");
    c_burst_two: cover property (st_reg.state == ba_burst && !bi.burst_ready_n ##1 !bi.burst_ready_n);
endmodule
`default_nettype wire

//--- idwba_top.sv
`include "idwba_consts.svh"
`default_nettype none
module idwba_top
    import idwba_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // cpu bus qualifiers
    input  wire logic       address_qualify_n,
    input  wire logic       dram_chip_select_n,
    input  wire logic       latched_write_read,
    input  wire logic       latched_addr2,
    input  wire logic       cycle_in_progress_n,
    input  wire logic [3:0] cpu_byte_enables_n,
    input  wire logic       cpu_ready_n,
    input  wire logic       write_miss,
    // cas state machine feedback
    input  wire logic       bank0_cas_write_state_n,
    input  wire logic       bank1_cas_write_state_n,
    input  wire logic       bank0_col_strobe_n,
    input  wire logic       bank1_col_strobe_n,
    // burst address sources
    input  wire logic       cpu_addr3,
    input  wire logic       address_latch_en,
    input  wire logic       burst_read_start,
    input  wire logic       burst_read_end,
    input  wire logic       memory_burst_ready_n,
    input  wire logic       bank_data_select,
    input  wire logic       read_page_miss,
    input  wire logic       row_addr13,
    input  wire logic       bank0_mux_addr_bit,
    input  wire logic       bank1_mux_addr_bit,
    // address path control
    output logic            bank0_write_path_sel,
    output logic            bank1_write_path_sel,
    output logic            bank0_write_strobe_en,
    output logic            bank1_write_strobe_en,
    // dram write strobes
    output logic [3:0]      bank0_byte_write_strobes_n,
    output logic [3:0]      bank1_byte_write_strobes_n,
    // status to ras and cas logic
    output logic            write_in_progress_n,
    output logic            cs_write_in_progress_n,
    output logic            cas_write_release,
    // dram low address pins
    output logic            bank0_low_addr_bit,
    output logic            bank1_low_addr_bit
);
    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    idwba_wr_reg_type   wr_reg;
    idwba_wr_reg_type   wr_next;
    idwba_burst_in_type burst_in;
    logic               valid_write;
    logic               start0;
    logic               start1;
    logic               another0;
    logic               another1;
    logic               ws_active;

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    function automatic idwba_sel_state_type sel_step(
        input idwba_sel_state_type cur,
        input logic                start,
        input logic                col_n,
        input logic                another
    );
        idwba_sel_state_type nxt;
        nxt = cur;
        case (cur)
            sel_idle: begin
                if (start) begin
                    nxt = sel_hold;
                end
            end
            sel_hold: begin
                // cas sampled active means the posted write has landed
                if (!col_n) begin
                    nxt = another ? sel_hold : sel_idle;
                end
            end
            default: nxt = sel_idle;
        endcase
        return nxt;
    endfunction

    function automatic logic we_step(
        input logic                cur,
        input logic                start,
        input idwba_sel_state_type sel,
        input logic                ws_n
    );
        logic nxt;
        nxt = cur;
        if (!cur && start) begin
            nxt = 1'b1;
        end else if (cur && sel == sel_idle && ws_n && !start) begin
            // waits for the select to drop and the cas write state to end, so it outlasts the select by at least a clock
            nxt = 1'b0;
        end
        return nxt;
    endfunction

    function automatic logic [3:0] byte_strobes(
        input logic       we,
        input logic [3:0] be_n
    );
        return be_n | {4{~we}};
    endfunction

    // -------------------------------------------------------------
    // write decode
    // -------------------------------------------------------------
    always_comb begin
        valid_write = !address_qualify_n && !dram_chip_select_n && latched_write_read;
        start0      = valid_write && latched_addr2 == `IDWBA_BANK0_A2;
        start1      = valid_write && latched_addr2 == `IDWBA_BANK1_A2;
        another0    = !cycle_in_progress_n && start0;
        another1    = !cycle_in_progress_n && start1;
        ws_active   = !bank0_cas_write_state_n || !bank1_cas_write_state_n;
    end

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb begin
        wr_next             = wr_reg;
        // a read behind a write simply finds the select still held
        wr_next.sel0        = sel_step(wr_reg.sel0, start0, bank0_col_strobe_n, another0);
        wr_next.sel1        = sel_step(wr_reg.sel1, start1, bank1_col_strobe_n, another1);
        wr_next.wen0        = we_step(wr_reg.wen0, start0, wr_reg.sel0, bank0_cas_write_state_n);
        wr_next.wen1        = we_step(wr_reg.wen1, start1, wr_reg.sel1, bank1_cas_write_state_n);
        wr_next.busy_hold   = ws_active;
        wr_next.cas_release = !cpu_ready_n && !write_miss;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_reg <= '{sel0: sel_idle, sel1: sel_idle, wen0: `IDWBA_WE_RST, wen1: `IDWBA_WE_RST,
                        busy_hold: `IDWBA_BUSY_HOLD_RST, cas_release: `IDWBA_CAS_REL_RST};
        end else begin
            wr_reg <= wr_next;
        end
    end

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    always_comb begin
        bank0_write_path_sel       = wr_reg.sel0 == sel_hold;
        bank1_write_path_sel       = wr_reg.sel1 == sel_hold;
        bank0_write_strobe_en      = wr_reg.wen0;
        bank1_write_strobe_en      = wr_reg.wen1;
        bank0_byte_write_strobes_n = byte_strobes(wr_reg.wen0, cpu_byte_enables_n);
        bank1_byte_write_strobes_n = byte_strobes(wr_reg.wen1, cpu_byte_enables_n);
        // combinational half keeps refresh from slipping in front of a write miss
        write_in_progress_n        = !(ws_active || wr_reg.busy_hold);
        cs_write_in_progress_n     = write_in_progress_n || dram_chip_select_n;
        cas_write_release          = wr_reg.cas_release;
    end

    // -------------------------------------------------------------
    // low address bits
    // -------------------------------------------------------------
    always_comb begin
        burst_in = '{addr3: cpu_addr3, addr_latch_en: address_latch_en,
                     burst_start: burst_read_start, burst_end: burst_read_end,
                     burst_ready_n: memory_burst_ready_n, data_select: bank_data_select,
                     read_page_miss: read_page_miss, row_addr13: row_addr13};
    end

    idwba_low_addr #(
        .BANK_DSEL (`IDWBA_BANK0_DSEL)
    ) u_bank0_addr (
        .clk          (clk),
        .resetn       (resetn),
        .bi           (burst_in),
        .own_write_en (wr_reg.wen0),
        .any_write_en (wr_reg.wen0 || wr_reg.wen1),
        .mux_addr_bit (bank0_mux_addr_bit),
        .low_addr_bit (bank0_low_addr_bit)
    );

    idwba_low_addr #(
        .BANK_DSEL (`IDWBA_BANK1_DSEL)
    ) u_bank1_addr (
        .clk          (clk),
        .resetn       (resetn),
        .bi           (burst_in),
        .own_write_en (wr_reg.wen1),
        .any_write_en (wr_reg.wen0 || wr_reg.wen1),
        .mux_addr_bit (bank1_mux_addr_bit),
        .low_addr_bit (bank1_low_addr_bit)
    );

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_sel0_start;
        start0 && !bank0_write_path_sel |=> bank0_write_path_sel;
    endproperty
    a_sel0_start: assert property (p_sel0_start) else $error("bank0 select missed write");

    property p_sel1_start;
        start1 && !bank1_write_path_sel |=> bank1_write_path_sel;
    endproperty
    a_sel1_start: assert property (p_sel1_start) else $error("bank1 select missed write");

    property p_sel0_release;
        bank0_write_path_sel && !bank0_col_strobe_n && !another0 |=> !bank0_write_path_sel;
    endproperty
    a_sel0_release: assert property (p_sel0_release) else $error("bank0 select stuck");

    property p_sel0_b2b;
        bank0_write_path_sel && !bank0_col_strobe_n && another0 |=> bank0_write_path_sel;
    endproperty
    a_sel0_b2b: assert property (p_sel0_b2b) else $error("bank0 select dropped on back-to-back");

    property p_sel0_hold;
        bank0_write_path_sel && bank0_col_strobe_n |=> bank0_write_path_sel;
    endproperty
    a_sel0_hold: assert property (p_sel0_hold) else $error("bank0 select left early");

    property p_we_with_sel;
        $rose(bank0_write_path_sel) |-> bank0_write_strobe_en;
    endproperty
    a_we_with_sel: assert property (p_we_with_sel) else $error("bank0 enable late");

    property p_we_outlasts;
        $fell(bank0_write_path_sel) |-> bank0_write_strobe_en;
    endproperty
    a_we_outlasts: assert property (p_we_outlasts) else $error("bank0 enable dropped with select");

    property p_strobe_gate;
        bank1_write_strobe_en |-> bank1_byte_write_strobes_n == cpu_byte_enables_n;
    endproperty
    a_strobe_gate: assert property (p_strobe_gate) else $error("bank1 byte strobes wrong");

    property p_strobe_idle;
        !bank0_write_strobe_en |-> bank0_byte_write_strobes_n == 4'hf;
    endproperty
    a_strobe_idle: assert property (p_strobe_idle) else $error("bank0 strobes active while idle");

    property p_busy_same;
        !bank0_cas_write_state_n || !bank1_cas_write_state_n |-> !write_in_progress_n;
    endproperty
    a_busy_same: assert property (p_busy_same) else $error("progress flag not same clock");

    property p_busy_tail;
        ws_active ##1 !ws_active |-> !write_in_progress_n ##1 (ws_active || write_in_progress_n);
    endproperty
    a_busy_tail: assert property (p_busy_tail) else $error("progress flag tail not one clock");

    property p_cswip;
        !write_in_progress_n && !dram_chip_select_n |-> !cs_write_in_progress_n;
    endproperty
    a_cswip: assert property (p_cswip) else $error("ras restart term missing");

    property p_cas_release;
        !cpu_ready_n && !write_miss |=> cas_write_release;
    endproperty
    a_cas_release: assert property (p_cas_release) else $error("cas release not after ready");

    property p_cas_wait;
        write_miss |=> !cas_write_release;
    endproperty
    a_cas_wait: assert property (p_cas_wait) else $error("cas released during write miss");

    property p_low_write;
        bank0_write_strobe_en |-> bank0_low_addr_bit == bank0_mux_addr_bit;
    endproperty
    a_low_write: assert property (p_low_write) else $error("write address not passed");

    property p_low_row;
        !bank1_write_strobe_en && !bank0_write_strobe_en && read_page_miss
            |-> bank1_low_addr_bit == row_addr13;
    endproperty
    a_low_row: assert property (p_low_row) else $error("row bit not driven on miss");

    property p_sel1_release;
        bank1_write_path_sel && !bank1_col_strobe_n && !another1 |=> !bank1_write_path_sel;
    endproperty
    a_sel1_release: assert property (p_sel1_release) else $error("bank1 select stuck");

    property p_sel1_b2b;
        bank1_write_path_sel && !bank1_col_strobe_n && another1 |=> bank1_write_path_sel;
    endproperty
    a_sel1_b2b: assert property (p_sel1_b2b) else $error("bank1 select dropped on back-to-back");

    property p_we_release;
        bank0_write_strobe_en && !bank0_write_path_sel && bank0_cas_write_state_n && !start0
            |=> !bank0_write_strobe_en;
    endproperty
    a_we_release: assert property (p_we_release) else $error("bank0 enable held after write");

    c_b2b_write:  cover property (bank0_write_path_sel && !bank0_col_strobe_n && another0);
    c_busy_tail:  cover property (ws_active ##1 !ws_active ##1 write_in_progress_n);
    c_we_outlast: cover property ($fell(bank1_write_path_sel) && bank1_write_strobe_en);
    c_read_miss:  cover property (read_page_miss && !bank0_write_strobe_en && !bank1_write_strobe_en);
endmodule
`default_nettype wire

//--- idwba_dummy_never.sv
`default_nettype none
`default_nettype wire

//--- idwba_cas_partner.sv
`default_nettype none
module idwba_cas_partner (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // from the write control
    input  wire logic       write_path_sel,
    input  wire logic [3:0] delay_clks,
    // cas feedback
    output var logic        cas_write_state_n,
    output var logic        col_strobe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt;
    // write state opens on a seen select; cas comes only after the chosen wait, like a slow ready
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 4'h0;
            cas_write_state_n <= 1'h1;
            col_strobe_n <= 1'h1;
        end else begin
            col_strobe_n <= 1'h1;
            if (cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
                col_strobe_n <= (cnt == 4'h1) ? 1'h0 : 1'h1;
            end else if (write_path_sel && cas_write_state_n) begin
                cas_write_state_n <= 1'h0;
                cnt <= delay_clks;
            end else if (!cas_write_state_n && col_strobe_n) begin
                cas_write_state_n <= 1'h1;
            end
        end
    end
endmodule
`default_nettype wire

//--- interleaved_dram_write_and_burst_addr_tb.sv
`include "idwba_consts.svh"
`default_nettype none
`define IDWBA_CHK(got, exp) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) begin \
            err_count++; \
            $display("[ERR] t=%0t got %h exp %h", $time, (got), (exp)); \
        end \
    end
module interleaved_dram_write_and_burst_addr_tb
    import idwba_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'h0, resetn = 1'h0;
    logic       address_qualify_n, dram_chip_select_n, latched_write_read, latched_addr2, cycle_in_progress_n;
    logic       cpu_ready_n, write_miss, cpu_addr3, address_latch_en, burst_read_start, burst_read_end;
    logic       memory_burst_ready_n, bank_data_select, read_page_miss, row_addr13;
    logic       bank0_mux_addr_bit, bank1_mux_addr_bit;
    logic       bank0_cas_write_state_n, bank1_cas_write_state_n, bank0_col_strobe_n, bank1_col_strobe_n;
    logic       bank0_write_path_sel, bank1_write_path_sel, bank0_write_strobe_en, bank1_write_strobe_en;
    logic       write_in_progress_n, cs_write_in_progress_n, cas_write_release;
    logic       bank0_low_addr_bit, bank1_low_addr_bit;
    logic [3:0] cpu_byte_enables_n, bank0_byte_write_strobes_n, bank1_byte_write_strobes_n, dly;
    bit   [1:0] m_sel = 2'h0, m_we = 2'h0, m_st = 2'h0, m_bit = 2'h0;
    bit         m_hold = 1'h0, m_rel = 1'h0, v, st, col, ws, nwe, wipn;
    int         wp, a2f, err_count = 0, n_tests = 0;

    idwba_top i_dut (.clk(clk), .resetn(resetn), .address_qualify_n(address_qualify_n),
        .dram_chip_select_n(dram_chip_select_n), .latched_write_read(latched_write_read),
        .latched_addr2(latched_addr2), .cycle_in_progress_n(cycle_in_progress_n),
        .cpu_byte_enables_n(cpu_byte_enables_n), .cpu_ready_n(cpu_ready_n), .write_miss(write_miss),
        .bank0_cas_write_state_n(bank0_cas_write_state_n), .bank1_cas_write_state_n(bank1_cas_write_state_n),
        .bank0_col_strobe_n(bank0_col_strobe_n), .bank1_col_strobe_n(bank1_col_strobe_n),
        .cpu_addr3(cpu_addr3), .address_latch_en(address_latch_en), .burst_read_start(burst_read_start),
        .burst_read_end(burst_read_end), .memory_burst_ready_n(memory_burst_ready_n),
        .bank_data_select(bank_data_select), .read_page_miss(read_page_miss), .row_addr13(row_addr13),
        .bank0_mux_addr_bit(bank0_mux_addr_bit), .bank1_mux_addr_bit(bank1_mux_addr_bit),
        .bank0_write_path_sel(bank0_write_path_sel), .bank1_write_path_sel(bank1_write_path_sel),
        .bank0_write_strobe_en(bank0_write_strobe_en), .bank1_write_strobe_en(bank1_write_strobe_en),
        .bank0_byte_write_strobes_n(bank0_byte_write_strobes_n),
        .bank1_byte_write_strobes_n(bank1_byte_write_strobes_n),
        .write_in_progress_n(write_in_progress_n), .cs_write_in_progress_n(cs_write_in_progress_n),
        .cas_write_release(cas_write_release), .bank0_low_addr_bit(bank0_low_addr_bit),
        .bank1_low_addr_bit(bank1_low_addr_bit));
    idwba_cas_partner i_cas0 (.clk(clk), .resetn(resetn), .write_path_sel(bank0_write_path_sel),
        .delay_clks(dly), .cas_write_state_n(bank0_cas_write_state_n), .col_strobe_n(bank0_col_strobe_n));
    idwba_cas_partner i_cas1 (.clk(clk), .resetn(resetn), .write_path_sel(bank1_write_path_sel),
        .delay_clks(dly + 4'h1), .cas_write_state_n(bank1_cas_write_state_n), .col_strobe_n(bank1_col_strobe_n));

    always #(`IDWBA_CLK_PERIOD_NS / 2) clk = ~clk;

    // -------------------------------------------------------------
    // reference model, one step per clock
    // -------------------------------------------------------------
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            m_sel = 2'h0;
            m_we = 2'h0;
            m_st = 2'h0;
            m_bit = 2'h0;
            m_hold = 1'h0;
            m_rel = 1'h0;
        end else begin
            v = !address_qualify_n && !dram_chip_select_n && latched_write_read;
            for (int b = 0; b < 2; b++) begin
                st = v && (latched_addr2 == 1'(b));
                col = b ? !bank1_col_strobe_n : !bank0_col_strobe_n;
                ws = b ? !bank1_cas_write_state_n : !bank0_cas_write_state_n;
                nwe = st || (m_we[b] && (m_sel[b] || ws));
                if (!m_sel[b]) begin
                    m_sel[b] = st;
                end else if (col) begin
                    m_sel[b] = !cycle_in_progress_n && st;
                end
                m_we[b] = nwe;
                if (!m_st[b]) begin
                    if (address_latch_en) begin
                        m_bit[b] = cpu_addr3;
                    end
                    if (burst_read_start) begin
                        m_st[b] = 1'h1;
                    end
                end else begin
                    if (!memory_burst_ready_n && bank_data_select == 1'(b)) begin
                        m_bit[b] = !m_bit[b];
                    end
                    if (burst_read_end) begin
                        m_st[b] = 1'h0;
                    end
                end
            end
            m_hold = !bank0_cas_write_state_n || !bank1_cas_write_state_n;
            m_rel = !cpu_ready_n && !write_miss;
        end
    end

    function automatic logic low_addr(int b);
        if (m_we[b]) begin
            return b ? bank1_mux_addr_bit : bank0_mux_addr_bit;
        end
        if (read_page_miss && m_we == 2'h0) begin
            return row_addr13;
        end
        return m_bit[b];
    endfunction

    // outputs have settled by the falling edge, combinational ones included
    always @(negedge clk) begin
        wipn = !(!bank0_cas_write_state_n || !bank1_cas_write_state_n || m_hold);
        `IDWBA_CHK({bank1_write_path_sel, bank0_write_path_sel}, m_sel)
        `IDWBA_CHK({bank1_write_strobe_en, bank0_write_strobe_en}, m_we)
        `IDWBA_CHK(bank0_byte_write_strobes_n, cpu_byte_enables_n | {4{!m_we[0]}})
        `IDWBA_CHK(bank1_byte_write_strobes_n, cpu_byte_enables_n | {4{!m_we[1]}})
        `IDWBA_CHK(write_in_progress_n, wipn)
        `IDWBA_CHK(cs_write_in_progress_n, wipn | dram_chip_select_n)
        `IDWBA_CHK(cas_write_release, m_rel)
        `IDWBA_CHK({bank1_low_addr_bit, bank0_low_addr_bit}, {low_addr(1), low_addr(0)})
    end

    // -------------------------------------------------------------
    // stimulus
    // -------------------------------------------------------------
    task automatic drive();
        int e;
        e = $urandom_range(0, 5);
        address_qualify_n <= ($urandom_range(0, 99) >= wp);
        dram_chip_select_n <= ($urandom_range(0, 9) == 0);
        latched_write_read <= ($urandom_range(0, 9) != 0);
        latched_addr2 <= (a2f < 0) ? 1'($urandom) : 1'(a2f);
        cycle_in_progress_n <= (a2f >= 0) ? 1'h0 : 1'($urandom);
        cpu_byte_enables_n <= 4'($urandom);
        {cpu_ready_n, write_miss, cpu_addr3, memory_burst_ready_n, bank_data_select} <= 5'($urandom);
        {read_page_miss, row_addr13, bank0_mux_addr_bit, bank1_mux_addr_bit} <= 4'($urandom);
        // latch, start and end never coincide, their joint order is left open
        address_latch_en <= (e == 1);
        burst_read_start <= (e == 2);
        burst_read_end <= (e == 3);
    endtask

    task automatic run(string nm, int n, int w, int a, int d);
        wp = w;
        a2f = a;
        dly <= 4'(d);
        repeat (n) begin
            @(posedge clk);
            drive();
        end
        $display("test %s done, checks %0d, errors %0d", nm, n_tests, err_count);
    endtask

    task automatic close_out();
        $display("checks %0d, errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #(10000 * `IDWBA_CLK_PERIOD_NS);
        err_count++;
        close_out();
    end

    initial begin
        void'($urandom(44577));
        wp = 50;
        a2f = -1;
        dly <= 4'h1;
        drive();
        repeat (4) @(posedge clk);
        resetn <= 1'h1;
        run("fast partner", 600, 50, -1, 1);
        run("slow partner", 600, 50, -1, 4);
        run("same bank 0", 300, 95, 0, 2);
        run("same bank 1", 300, 95, 1, 3);
        @(posedge clk);
        resetn <= 1'h0;
        repeat (2) @(posedge clk);
        resetn <= 1'h1;
        run("after reset", 300, 20, -1, 1);
        close_out();
    end
endmodule
`default_nettype wire
